// ---- rtl/umcs_defs.svh ----
// Offsets, field positions, reset values and fixed widths of the modem pins.
// Assumes inclusion by bare name from every file that needs these constants.
`ifndef UMCS_DEFS_SVH
`define UMCS_DEFS_SVH

// ****************************************************************
// Register byte offsets on the APB bus
// ****************************************************************
`define UMCS_ADDR_W        12
`define UMCS_OFF_MCR       12'h000
`define UMCS_OFF_MSR       12'h004
`define UMCS_OFF_IER       12'h008
`define UMCS_OFF_BUS       12'h00C

// ****************************************************************
// Modem control register fields
// ****************************************************************
`define UMCS_MCR_W         6
`define UMCS_MCR_DTR       0
`define UMCS_MCR_RTS       1
`define UMCS_MCR_OUTA      2
`define UMCS_MCR_OUTB      3
`define UMCS_MCR_LOOP      4
`define UMCS_MCR_AUTOCTS   5
`define UMCS_MCR_RST       6'h00

// ****************************************************************
// Modem status register fields
// ****************************************************************
`define UMCS_MSR_DCTS      0
`define UMCS_MSR_DDSR      1
`define UMCS_MSR_DDCD      3
`define UMCS_MSR_CTS       4
`define UMCS_MSR_DSR       5
`define UMCS_MSR_DCD       7

// ****************************************************************
// Interrupt enable register fields
// ****************************************************************
`define UMCS_IER_W         4
`define UMCS_IER_RXDATA    0
`define UMCS_IER_THRE      1
`define UMCS_IER_LINE      2
`define UMCS_IER_MODEM     3
`define UMCS_IER_RST       4'h0

// ****************************************************************
// Synchroniser lanes: three modem inputs, reset, eight data lines
// ****************************************************************
`define UMCS_SYNC_W        12
`define UMCS_LN_CTS        0
`define UMCS_LN_DSR        1
`define UMCS_LN_DCD        2
`define UMCS_LN_MRST       3
`define UMCS_LN_DATA       4
`define UMCS_DATA_W        8
`define UMCS_SYNC_RST      12'h007

`endif

// ---- rtl/umcs_pkg.sv ----
// Types shared by the modem control and status block.
// Assumes umcs_defs.svh is on the include path.
`include "umcs_defs.svh"

package umcs_pkg;

	// ****************************************************************
	// Bus phase
	// ****************************************************************
	typedef enum logic [1:0] {
		UMCS_IDLE   = 2'b01,
		UMCS_ACCESS = 2'b10
	} umcs_phase_type;

	// ****************************************************************
	// Whole state of the main module
	// ****************************************************************
	typedef struct packed {
		umcs_phase_type             phase;
		logic [`UMCS_MCR_W-1:0]     modem_control_reg;
		logic [`UMCS_IER_W-1:0]     ier;
		logic [2:0]                 dflag;
		logic [2:0]                 prev;
		logic [2:0]                 rpt;
		logic                       primed;
		logic                       pready;
		logic                       pslverr;
		logic [31:0]                prdata;
		logic                       int_req;
		logic                       dtr_n;
		logic                       out_a_n;
		logic                       out_b_n;
		logic                       bus_driver_disable_n_n;
		logic [`UMCS_DATA_W-1:0]    data_o;
		logic                       data_oe;
		logic                       tx_en;
	} umcs_state_type;

	// ****************************************************************
	// Whole state of the synchroniser
	// ****************************************************************
	typedef struct packed {
		logic [`UMCS_SYNC_W-1:0]    meta;
		logic [`UMCS_SYNC_W-1:0]    stable;
	} umcs_sync_state_type;

endpackage

// ---- rtl/umcs_sync_if.sv ----
// Carrier between the main module and its pin synchroniser.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
`include "umcs_defs.svh"

interface umcs_sync_if;
	logic [`UMCS_SYNC_W-1:0]    raw;
	logic [`UMCS_SYNC_W-1:0]    synced;

	modport owner (output raw, input synced);
	modport sync (input raw, output synced);
endinterface

// ---- rtl/umcs_sync.sv ----
// Two-stage synchroniser for every asynchronous pin of the block.
// Assumes the raw levels come straight from pins outside the clock domain.
`timescale 1ns/1ps
`include "umcs_defs.svh"

module umcs_sync (
	// Clock and reset
	input  wire logic           clock_i,
	input  wire logic           arst_n_i,
	// Pin lanes
	umcs_sync_if.sync           lanes
);

	umcs_pkg::umcs_sync_state_type s_r;
	umcs_pkg::umcs_sync_state_type s_nxt;

	// The first stage feeds the second stage and nothing else.
	always_comb begin
		s_nxt        = s_r;
		s_nxt.meta   = lanes.raw;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			// Modem lines reset to their idle level, so no false change
			// shows up when the first real samples arrive.
			s_r <= '{meta: `UMCS_SYNC_RST, stable: `UMCS_SYNC_RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lanes.synced = s_r.stable;

endmodule // umcs_sync

// ---- rtl/umcs_top.sv ----
// Modem control and status pins of a single-channel UART, with APB access.
// Assumes the rest of the UART supplies its interrupt causes as levels.
// Assumes those levels come from logic on this same clock, with no sync.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "umcs_defs.svh"

module umcs_top (
	// Clock and reset
	input  wire logic                       clock_i,
	input  wire logic                       arst_n_i,
	// APB slave
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [`UMCS_ADDR_W-1:0]    paddr_i,
	input  wire logic [31:0]                pwdata_i,
	output logic      [31:0]                prdata_o,
	output logic                            pready_o,
	output logic                            pslverr_o,
	// Modem status pins, active low
	input  wire logic                       cts_n_i,
	input  wire logic                       dsr_n_i,
	input  wire logic                       dcd_n_i,
	// Master reset pin, active high
	input  wire logic                       master_reset_i,
	// Host data lines and transceiver control
	input  wire logic [`UMCS_DATA_W-1:0]    host_data_i,
	output logic      [`UMCS_DATA_W-1:0]    host_data_o,
	output logic                            host_data_oe_o,
	output logic                            bus_driver_disable_n_o,
	// Modem control pins, active low
	output logic                            dtr_n_o,
	output logic                            user_output_a_n_o,
	output logic                            user_output_b_n_o,
	// Interrupt causes from the rest of the UART
	input  wire logic                       line_error_i,
	input  wire logic                       rx_data_avail_i,
	input  wire logic                       rx_timeout_i,
	input  wire logic                       fifo_mode_i,
	input  wire logic                       thr_empty_i,
	// Interrupt and transmitter gate
	output logic                            int_o,
	output logic                            tx_enable_o
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	umcs_sync_if lanes ();

	// The host data lines are only a static diagnostic view, never a data
	// path, so a byte torn across two samples does no harm.
	assign lanes.raw = {host_data_i, master_reset_i,
		dcd_n_i, dsr_n_i, cts_n_i};

	umcs_sync u_sync (
		.clock_i  (clock_i),
		.arst_n_i (arst_n_i),
		.lanes    (lanes)
	);

	logic                       mrst;
	logic [2:0]                 pin_lvl;
	logic [`UMCS_DATA_W-1:0]    bus_sample;

	assign mrst       = lanes.synced[`UMCS_LN_MRST];
	assign bus_sample = lanes.synced[`UMCS_LN_DATA +: `UMCS_DATA_W];
	// Pins are active low; status bits read one while the signal is active.
	assign pin_lvl    = ~lanes.synced[`UMCS_LN_DCD:`UMCS_LN_CTS];

	// ****************************************************************
	// State
	// ****************************************************************
	umcs_pkg::umcs_state_type s_r;
	umcs_pkg::umcs_state_type s_nxt;

	localparam umcs_pkg::umcs_state_type UMCS_RST_STATE = '{
		phase:   umcs_pkg::UMCS_IDLE,
		modem_control_reg:     `UMCS_MCR_RST,
		ier:     `UMCS_IER_RST,
		dflag:   3'h0,
		prev:    3'h0,
		rpt:     3'h0,
		primed:  1'b0,
		pready:  1'b0,
		pslverr: 1'b0,
		prdata:  32'h0000_0000,
		int_req: 1'b0,
		dtr_n:   1'b1,
		out_a_n: 1'b1,
		out_b_n: 1'b1,
		bus_driver_disable_n_n:  1'b1,
		data_o:  8'h00,
		data_oe: 1'b0,
		tx_en:   1'b1
	};

	// ****************************************************************
	// Read view of the registers
	// ****************************************************************
	logic [2:0]     lvl;
	logic [2:0]     chg;
	logic [2:0]     clr;
	logic [7:0]     msr_view;
	logic [31:0]    rd_word;
	logic           mapped;
	logic           modem_pend;
	logic           other_pend;
	logic           dsr_cause;
	logic           dcd_cause;
	logic           cts_cause;
	logic           line_cause;
	logic           rx_cause;
	logic           thr_cause;
	logic           pins_off;

	// In loopback the status bits follow the control bits, not the pins.
	always_comb begin
		if (s_r.modem_control_reg[`UMCS_MCR_LOOP]) begin
			lvl = {s_r.modem_control_reg[`UMCS_MCR_OUTB], s_r.modem_control_reg[`UMCS_MCR_DTR],
				s_r.modem_control_reg[`UMCS_MCR_RTS]};
		end else begin
			lvl = pin_lvl;
		end
	end

	// ****************************************************************
	// Change detection
	// ****************************************************************

	// The first cycle after any reset only primes the history, so after a master
	// reset the levels present do not show up as changes; after arst_n_i active lines do.
	assign chg = s_r.primed ? (lvl ^ s_r.prev) : 3'h0;

	// ****************************************************************
	// Status word
	// ****************************************************************

	always_comb begin
		msr_view                = 8'h00;
		msr_view[`UMCS_MSR_CTS]  = lvl[0];
		msr_view[`UMCS_MSR_DSR]  = lvl[1];
		msr_view[`UMCS_MSR_DCD]  = lvl[2];
		msr_view[`UMCS_MSR_DCTS] = s_r.dflag[0];
		msr_view[`UMCS_MSR_DDSR] = s_r.dflag[1];
		msr_view[`UMCS_MSR_DDCD] = s_r.dflag[2];
	end

	// ****************************************************************
	// Register read mux
	// ****************************************************************

	always_comb begin
		mapped  = 1'b1;
		rd_word = 32'h0000_0000;
		case (paddr_i)
			`UMCS_OFF_MCR: begin
				rd_word[`UMCS_MCR_W-1:0] = s_r.modem_control_reg;
			end
			`UMCS_OFF_MSR: begin
				rd_word[7:0] = msr_view;
			end
			`UMCS_OFF_IER: begin
				rd_word[`UMCS_IER_W-1:0] = s_r.ier;
			end
			`UMCS_OFF_BUS: begin
				rd_word[`UMCS_DATA_W-1:0] = bus_sample;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Bus phase decode
	// ****************************************************************
	logic           setup_seen;
	logic           access_seen;
	logic           msr_addr;

	// A setup counts only in idle and an access only in the access phase,
	// so a master that stretches a phase cannot start a second transfer.
	assign setup_seen  = psel_i && !penable_i;
	assign access_seen = psel_i && penable_i;
	assign msr_addr    = (paddr_i == `UMCS_OFF_MSR);

	// ****************************************************************
	// Bus handling and next state
	// ****************************************************************
	always_comb begin
		s_nxt        = s_r;
		clr          = 3'h0;
		s_nxt.prev   = lvl;
		s_nxt.primed = 1'b1;

		case (s_r.phase)
			umcs_pkg::UMCS_IDLE: begin
				// Read data is captured here and stands through the access.
				if (setup_seen) begin
					s_nxt.phase   = umcs_pkg::UMCS_ACCESS;
					s_nxt.pready  = 1'b1;
					s_nxt.pslverr = !mapped;
					s_nxt.prdata  = pwrite_i ? 32'h0000_0000 : rd_word;
					s_nxt.rpt     = 3'h0;
					if (!pwrite_i) begin
						s_nxt.bus_driver_disable_n_n  = 1'b0;
						s_nxt.data_oe = 1'b1;
						s_nxt.data_o  = rd_word[`UMCS_DATA_W-1:0];
						if (msr_addr) begin
							s_nxt.rpt = s_r.dflag;
						end
					end
				end
			end
			umcs_pkg::UMCS_ACCESS: begin
				// Writes land at the edge that shows pready and ends it.
				if (access_seen) begin
					s_nxt.phase   = umcs_pkg::UMCS_IDLE;
					s_nxt.pready  = 1'b0;
					s_nxt.pslverr = 1'b0;
					s_nxt.bus_driver_disable_n_n  = 1'b1;
					s_nxt.data_oe = 1'b0;
					if (pwrite_i) begin
						case (paddr_i)
							`UMCS_OFF_MCR: begin
								s_nxt.modem_control_reg = pwdata_i[`UMCS_MCR_W-1:0];
							end
							`UMCS_OFF_IER: begin
								s_nxt.ier = pwdata_i[`UMCS_IER_W-1:0];
							end
							default: begin
							end
						endcase
					end else if (msr_addr) begin
						// Only flags that went out in the data are cleared.
						clr = s_r.rpt;
					end
				end
			end
			default: begin
				s_nxt.phase   = umcs_pkg::UMCS_IDLE;
				s_nxt.pready  = 1'b0;
				s_nxt.bus_driver_disable_n_n  = 1'b1;
				s_nxt.data_oe = 1'b0;
			end
		endcase

		// A change in the clearing cycle survives the clear, so no edge on
		// a modem line is ever lost between two reads.
		s_nxt.dflag[0] = (s_r.dflag[0] && !clr[0]) || chg[0];
		s_nxt.dflag[1] = (s_r.dflag[1] && !clr[1]) || chg[1];
		s_nxt.dflag[2] = (s_r.dflag[2] && !clr[2]) || chg[2];

		// Master reset comes through the synchroniser, so it acts a few
		// edges late; a bus transfer already in flight still completes.
		if (mrst) begin
			s_nxt.modem_control_reg    = `UMCS_MCR_RST;
			s_nxt.ier    = `UMCS_IER_RST;
			s_nxt.dflag  = 3'h0;
			s_nxt.primed = 1'b0;
		end

		// Loopback parks every control pin at its inactive level, so the
		// modem never sees the patterns software uses for self test.
		pins_off      = s_nxt.modem_control_reg[`UMCS_MCR_LOOP];
		s_nxt.dtr_n   = !(s_nxt.modem_control_reg[`UMCS_MCR_DTR] &&
			!pins_off);
		s_nxt.out_a_n = !(s_nxt.modem_control_reg[`UMCS_MCR_OUTA] &&
			!pins_off);
		s_nxt.out_b_n = !(s_nxt.modem_control_reg[`UMCS_MCR_OUTB] &&
			!pins_off);

		// Auto gating only ever holds the transmitter back; with the mode
		// off the gate stays open whatever the clear-to-send level is.
		s_nxt.tx_en = !s_nxt.modem_control_reg[`UMCS_MCR_AUTOCTS] || lvl[0];

		// Causes are judged on the next state, so the status read that
		// clears the last modem flag drops the request at the same edge.
		dsr_cause  = s_nxt.dflag[1];
		dcd_cause  = s_nxt.dflag[2];
		cts_cause  = s_nxt.dflag[0] &&
			!s_nxt.modem_control_reg[`UMCS_MCR_AUTOCTS];
		modem_pend = s_nxt.ier[`UMCS_IER_MODEM] &&
			(dsr_cause || dcd_cause || cts_cause);
		line_cause = s_nxt.ier[`UMCS_IER_LINE] && line_error_i;
		rx_cause   = s_nxt.ier[`UMCS_IER_RXDATA] &&
			(rx_data_avail_i || (fifo_mode_i && rx_timeout_i));
		thr_cause  = s_nxt.ier[`UMCS_IER_THRE] && thr_empty_i;
		other_pend = line_cause || rx_cause || thr_cause;

		s_nxt.int_req = !mrst && (modem_pend || other_pend);
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_r <= UMCS_RST_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Outputs, each straight from the state register
	// ****************************************************************
	assign prdata_o               = s_r.prdata;
	assign pready_o               = s_r.pready;
	assign pslverr_o              = s_r.pslverr;
	assign host_data_o            = s_r.data_o;
	assign host_data_oe_o         = s_r.data_oe;
	assign bus_driver_disable_n_o = s_r.bus_driver_disable_n_n;
	assign dtr_n_o                = s_r.dtr_n;
	assign user_output_a_n_o      = s_r.out_a_n;
	assign user_output_b_n_o      = s_r.out_b_n;
	assign int_o                  = s_r.int_req;
	assign tx_enable_o            = s_r.tx_en;

endmodule // umcs_top

// ---- tb/umcs_top_sva.sv ----
// Concurrent checks on the pins of the modem control and status block.
// Assumes a master that holds each APB request until pready is seen.
`timescale 1ns/1ps
`include "umcs_defs.svh"

module umcs_top_sva (
	// Clock and reset
	input	wire logic			clock_i,
	input	wire logic			arst_n_i,
	// Bus, clear to send and master reset
	input	wire logic			psel_i,
	input	wire logic			penable_i,
	input	wire logic			pwrite_i,
	input	wire logic [`UMCS_ADDR_W-1:0]	paddr_i,
	input	wire logic [31:0]		pwdata_i,
	input	wire logic [31:0]		prdata_o,
	input	wire logic			pready_o,
	input	wire logic			cts_n_i,
	input	wire logic			master_reset_i,
	// Watched outputs
	input	wire logic [`UMCS_DATA_W-1:0]	host_data_o,
	input	wire logic			host_data_oe_o,
	input	wire logic			bus_driver_disable_n_o,
	input	wire logic			dtr_n_o,
	input	wire logic			user_output_a_n_o,
	input	wire logic			user_output_b_n_o,
	input	wire logic			int_o,
	input	wire logic			tx_enable_o
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_mcr_wr;
		psel_i && penable_i && pready_o && pwrite_i
			&& paddr_i == `UMCS_OFF_MCR;
	endsequence

	// Loopback holds every control pin inactive whatever its bit says.
	property p_pin(logic pin, int b);
		s_mcr_wr |-> ##2 pin == !($past(pwdata_i[b], 2)
			&& !$past(pwdata_i[`UMCS_MCR_LOOP], 2));
	endproperty

	AST_DTR_PIN: assert property (p_pin(dtr_n_o, `UMCS_MCR_DTR))
		else $error("terminal ready pin disagrees with control bits");
	AST_OUTA_PIN: assert property (p_pin(user_output_a_n_o, `UMCS_MCR_OUTA))
		else $error("user output a disagrees with control bits");
	AST_OUTB_PIN: assert property (p_pin(user_output_b_n_o, `UMCS_MCR_OUTB))
		else $error("user output b disagrees with control bits");
	AST_BUS_DRIVER_DISABLE_N_READ: assert property (bus_driver_disable_n_o == !(pready_o && !pwrite_i))
		else $error("driver disable not low exactly during reads");
	AST_OE_BUS_DRIVER_DISABLE_N: assert property (host_data_oe_o == !bus_driver_disable_n_o)
		else $error("data lines driven outside a read");
	AST_DATA_BYTE: assert property (host_data_oe_o |-> host_data_o == prdata_o[7:0])
		else $error("data lines differ from the read byte");
	AST_MRST_IDLE: assert property (master_reset_i [*6] |-> dtr_n_o && user_output_a_n_o && user_output_b_n_o && !int_o)
		else $error("outputs not idle under master reset");
	AST_TX_CTS: assert property (!cts_n_i [*6] |-> tx_enable_o)
		else $error("transmitter gated while clear to send active");
endmodule // umcs_top_sva

bind umcs_top umcs_top_sva i_umcs_top_sva (
	.clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pready_o, .cts_n_i, .master_reset_i,
	.host_data_o, .host_data_oe_o, .bus_driver_disable_n_o, .dtr_n_o,
	.user_output_a_n_o, .user_output_b_n_o, .int_o, .tx_enable_o
);

// ---- tb/umcs_modem.sv ----
// Behavioural modem driving the three status lines of the block.
// Assumes set_lines is called just after a rising clock edge.
`timescale 1ns/1ps

module umcs_modem (
	// Clock
	input	wire logic	clock_i,
	// Status lines, active low
	output	logic		cts_n_o,
	output	logic		dsr_n_o,
	output	logic		dcd_n_o
);
	// A modem that has not answered yet shows every line inactive.
	initial begin
		{dcd_n_o, dsr_n_o, cts_n_o} = 3'h7;
	end

	// Levels are active high {carrier, set ready, clear to send}.
	task automatic set_lines(input logic [2:0] act);
		{dcd_n_o, dsr_n_o, cts_n_o} <= ~act;
		@(posedge clock_i);
	endtask
endmodule // umcs_modem

// ---- tb/umcs_top_test.sv ----
// Self-checking bench for the modem control and status block.
// Assumes the block is the only APB slave and the modem model drives it.
`timescale 1ns/1ps
`include "umcs_defs.svh"

module umcs_top_test;
	logic		clock_i, arst_n_i, psel, penable, pwrite, mrst;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata;
	logic		pready, pslverr, cts_n, dsr_n, dcd_n, oe, bus_driver_disable_n_n;
	logic		dtr_n, outa_n, outb_n, int_w, tx_en;
	logic		le, rx, tmo, fifo, thr;
	logic [7:0]	cpu_data, dat_o;
	wire [7:0]	host_data;
	int		fails, compares;

	// The block drives the shared lines only while its enable is high.
	assign host_data = oe ? dat_o : cpu_data;

	umcs_top i_umcs_top (
		.clock_i, .arst_n_i, .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.cts_n_i(cts_n), .dsr_n_i(dsr_n), .dcd_n_i(dcd_n),
		.master_reset_i(mrst), .host_data_i(host_data),
		.host_data_o(dat_o), .host_data_oe_o(oe),
		.bus_driver_disable_n_o(bus_driver_disable_n_n), .dtr_n_o(dtr_n),
		.user_output_a_n_o(outa_n), .user_output_b_n_o(outb_n),
		.line_error_i(le), .rx_data_avail_i(rx), .rx_timeout_i(tmo),
		.fifo_mode_i(fifo), .thr_empty_i(thr), .int_o(int_w),
		.tx_enable_o(tx_en)
	);
	umcs_modem i_umcs_modem (.clock_i, .cts_n_o(cts_n),
		.dsr_n_o(dsr_n), .dcd_n_o(dcd_n));

	// ****
	// Tasks
	// ****
	task automatic final_report;
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, x);
		compares++;
		if (seen !== x) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, x, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// Starts on an edge of its own so back-to-back calls never collide.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clock_i);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'h1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			chk("pready", pready, 1'h1);
			final_report();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'h1, a, d, q, e);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'h0, a, 32'h0, q, e);
		chk(nm, q, x);
	endtask

	task automatic wait_int(input logic x);
		int n;
		n = 0;
		while (int_w !== x && n < 12) begin
			@(posedge clock_i);
			n++;
		end
		chk("int_o", int_w, x);
		if (int_w !== x) final_report();
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		logic [31:0] q;
		logic e;
		chk("pins", {dtr_n, outa_n, outb_n, bus_driver_disable_n_n, tx_en, int_w, oe}, 7'h7C);
		rdc("mcr", `UMCS_OFF_MCR, 32'h0);
		rdc("ier", `UMCS_OFF_IER, 32'h0);
		// The last read drove the shared lines; let the sampler see the CPU.
		cyc(3);
		rdc("data", `UMCS_OFF_BUS, 32'hA5);
		cpu_data <= 8'h5A;
		cyc(3);
		rdc("data", `UMCS_OFF_BUS, 32'h5A);
		apb(1'h0, 12'h010, 32'h0, q, e);
		chk("unmapped", {e, q[30:0]}, 32'h80000000);
	endtask

	task automatic t_ctrl;
		logic [5:0] v[6] = '{6'h01, 6'h04, 6'h08, 6'h0D, 6'h1D, 6'h00};
		logic a;
		foreach (v[i]) begin
			wr(`UMCS_OFF_MCR, {26'h0, v[i]});
			cyc(2);
			a = !v[i][4];
			chk("dtr_n", dtr_n, !(v[i][0] && a));
			chk("out_a_n", outa_n, !(v[i][2] && a));
			chk("out_b_n", outb_n, !(v[i][3] && a));
			rdc("mcr", `UMCS_OFF_MCR, {26'h0, v[i]});
		end
	endtask

	task automatic t_status;
		logic [2:0] s[4] = '{3'h1, 3'h3, 3'h6, 3'h0};
		logic [2:0] p, x;
		p = 3'h0;
		cyc(6);
		// Leaving loopback earlier moved the looped set-ready and carrier.
		rdc("msr", `UMCS_OFF_MSR, 32'h0A);
		rdc("msr", `UMCS_OFF_MSR, 32'h0);
		foreach (s[i]) begin
			i_umcs_modem.set_lines(s[i]);
			cyc(6);
			x = s[i] ^ p;
			rdc("msr", `UMCS_OFF_MSR, {24'h0, s[i][2], 1'h0, s[i][1:0], x[2], 1'h0, x[1:0]});
			rdc("msr", `UMCS_OFF_MSR, {24'h0, s[i][2], 1'h0, s[i][1:0], 4'h0});
			p = s[i];
		end
	endtask

	task automatic t_int;
		logic [4:0] c[4] = '{5'h01, 5'h02, 5'h04, 5'h18};
		logic [3:0] en[4] = '{4'h4, 4'h2, 4'h1, 4'h1};
		wr(`UMCS_OFF_IER, 32'h8);
		i_umcs_modem.set_lines(3'h2);
		wait_int(1'h1);
		rdc("msr", `UMCS_OFF_MSR, 32'h22);
		wait_int(1'h0);
		wr(`UMCS_OFF_MCR, 32'h20);
		i_umcs_modem.set_lines(3'h3);
		cyc(8);
		chk("int_o", int_w, 1'h0);
		rdc("msr", `UMCS_OFF_MSR, 32'h31);
		wr(`UMCS_OFF_MCR, 32'h0);
		i_umcs_modem.set_lines(3'h2);
		wait_int(1'h1);
		rdc("msr", `UMCS_OFF_MSR, 32'h21);
		wait_int(1'h0);
		wr(`UMCS_OFF_IER, 32'h0);
		i_umcs_modem.set_lines(3'h6);
		cyc(8);
		chk("int_o", int_w, 1'h0);
		foreach (c[i]) begin
			fifo <= c[i][4];
			tmo <= c[i][3];
			rx <= c[i][2];
			thr <= c[i][1];
			le <= c[i][0];
			wr(`UMCS_OFF_IER, 32'h0);
			cyc(4);
			chk("int_o", int_w, 1'h0);
			wr(`UMCS_OFF_IER, {28'h0, en[i]});
			wait_int(1'h1);
			fifo <= 1'h0;
			tmo <= 1'h0;
			rx <= 1'h0;
			thr <= 1'h0;
			le <= 1'h0;
			wait_int(1'h0);
		end
	endtask

	task automatic t_txen;
		wr(`UMCS_OFF_MCR, 32'h20);
		i_umcs_modem.set_lines(3'h0);
		cyc(6);
		chk("tx_en", tx_en, 1'h0);
		i_umcs_modem.set_lines(3'h1);
		cyc(6);
		chk("tx_en", tx_en, 1'h1);
		i_umcs_modem.set_lines(3'h0);
		wr(`UMCS_OFF_MCR, 32'h0);
		cyc(6);
		chk("tx_en", tx_en, 1'h1);
	endtask

	task automatic t_mreset;
		wr(`UMCS_OFF_MCR, 32'h0D);
		wr(`UMCS_OFF_IER, 32'h2);
		thr <= 1'h1;
		wait_int(1'h1);
		mrst <= 1'h1;
		cyc(8);
		chk("pins", {dtr_n, outa_n, outb_n, int_w}, 4'hE);
		mrst <= 1'h0;
		cyc(4);
		thr <= 1'h0;
		rdc("mcr", `UMCS_OFF_MCR, 32'h0);
		rdc("ier", `UMCS_OFF_IER, 32'h0);
	endtask

	// A second asynchronous reset in mid-run must not leave false changes.
	task automatic t_areset;
		wr(`UMCS_OFF_MCR, 32'h0D);
		arst_n_i <= 1'h0;
		cyc(2);
		chk("pins", {dtr_n, outa_n, outb_n, bus_driver_disable_n_n, tx_en, int_w, oe}, 7'h7C);
		arst_n_i <= 1'h1;
		cyc(2);
		rdc("mcr", `UMCS_OFF_MCR, 32'h0);
		rdc("msr", `UMCS_OFF_MSR, 32'h0);
	endtask

	initial begin
		clock_i = 1'h0;
		forever #20 clock_i = ~clock_i;
	end

	initial begin
		{arst_n_i, psel, penable, pwrite, mrst} = 5'h0;
		{le, rx, tmo, fifo, thr} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		cpu_data = 8'hA5;
		fails = 0;
		compares = 0;
		cyc(12);
		arst_n_i <= 1'h1;
		@(posedge clock_i);
		t_reset();
		t_ctrl();
		t_status();
		t_int();
		t_txen();
		t_mreset();
		t_areset();
		final_report();
	end
endmodule // umcs_top_test
